// ===== status_pkg.sv
package status_pkg;

    // Flash rates, in milliseconds per half period
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned SLOW_HALF_MS  = 500;
    localparam int unsigned FAST_HALF_MS  = 125;
    localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);

    // Address attempt time limits, in milliseconds
    localparam int unsigned STEP_TIMEOUT_MS  = 3000;
    localparam int unsigned STEP_TIMEOUT_CYC = STEP_TIMEOUT_MS * (CLK_HZ / 1000);

    // Factory defaults of the address options
    localparam logic PERSIST_EN_RESET = 1'b0;
    localparam logic DHCP_EN_RESET    = 1'b1;

    // Link-local subnet prefix
    localparam logic [15:0] LLA_PREFIX = 16'hA9FE;

    // Seed of the address picker after reset
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // Indicator colours, one bit each
    typedef enum logic [2:0] {
        COL_OFF   = 3'h0,
        COL_RED   = 3'h1,
        COL_GREEN = 3'h2,
        COL_BLUE  = 3'h4
    } colour_t;

    // Indicator patterns
    typedef enum logic [1:0] {
        PAT_STEADY = 2'h0,
        PAT_SLOW   = 2'h1,
        PAT_FAST   = 2'h2
    } pattern_t;

    // Address sequencer states
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_PERSIST = 7'h02,
        ST_DHCP    = 7'h04,
        ST_PICK    = 7'h08,
        ST_PROBE   = 7'h10,
        ST_BOUND   = 7'h20,
        ST_DOWN    = 7'h40
    } ip_state_t;

endpackage

// ===== flash_divider.sv
module flash_divider
    import status_pkg::*;
#(
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = FAST_HALF_CYC
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Flash phases
    output logic      slow_phase,
    output logic      fast_phase
);

    typedef struct packed {
        logic [31:0] slow_cnt;
        logic [31:0] fast_cnt;
        logic        slow_ph;
        logic        fast_ph;
    } div_t;

    div_t st;
    div_t next_st;

    // Two free counters toggle the flash phases
    always_comb begin
        next_st = st;
        if (st.slow_cnt == SLOW_HALF - 1) begin
            next_st.slow_cnt = 32'h0;
            next_st.slow_ph  = ~st.slow_ph;
        end else begin
            next_st.slow_cnt = st.slow_cnt + 32'h1;
        end
        if (st.fast_cnt == FAST_HALF - 1) begin
            next_st.fast_cnt = 32'h0;
            next_st.fast_ph  = ~st.fast_ph;
        end else begin
            next_st.fast_cnt = st.fast_cnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign slow_phase = st.slow_ph;
    assign fast_phase = st.fast_ph;

endmodule

// ===== status_sequencer.sv
// Notes on behaviour
// - Only the highest-priority active condition shows; acquisition beats assigned address.
// - Free-running acquisition shows fast flashing green.
// - Triggered acquisition shows slow flashing green.
// - No link shows fast flashing blue.
// - Link up without address shows slow flashing blue.
// - Address assigned, no application connected, shows steady blue.
// - Address tried as persistent if enabled, else DHCP, then link-local, always enabled.
// - Address sequence starts at power-up and on each link connection.
// - Persistent off and DHCP on after reset; link-local cannot be disabled.
// - Link-local picks random address, probes by ARP, adopts only if unanswered.
module status_sequencer
    import status_pkg::*;
#(
    parameter int unsigned SLOW_HALF    = SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF    = FAST_HALF_CYC,
    parameter int unsigned STEP_TIMEOUT = STEP_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Camera conditions
    input  wire logic        init_done,
    input  wire logic        init_fault,
    input  wire logic        over_temp,
    input  wire logic        link_up,
    input  wire logic        app_connected,
    input  wire logic        acq_free_run,
    input  wire logic        acq_triggered,
    // Address option settings and strobe
    input  wire logic        persist_en_in,
    input  wire logic        dhcp_en_in,
    input  wire logic        option_wr,
    input  wire logic [31:0] persist_addr,
    // Network engine: requests
    output logic             dhcp_start,
    output logic             arp_probe_start,
    output logic [31:0]      probe_addr,
    // Network engine: results
    input  wire logic        dhcp_ack,
    input  wire logic [31:0] dhcp_addr,
    input  wire logic        arp_reply,
    // Address state
    output logic             addr_valid,
    output logic [31:0]      ip_addr,
    output logic             persist_en,
    output logic             dhcp_en,
    // Indicator
    output logic             led_red,
    output logic             led_green,
    output logic             led_blue
);

    typedef struct packed {
        logic        rst_meta;
        logic        rst_sync;
    } rsync_t;

    typedef struct packed {
        ip_state_t   state;
        logic [31:0] timer;
        logic [15:0] lfsr;
        logic [31:0] addr;
        logic        valid;
        logic        p_en;
        logic        d_en;
        logic        link_d;
        logic        dhcp_go;
        logic        arp_go;
        logic [2:0]  led;
    } seq_t;

    rsync_t rs;
    seq_t   st;
    seq_t   next_st;
    logic   rst_n;
    logic   slow_phase;
    logic   fast_phase;
    logic [2:0] next_led;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rs <= '0;
        end else begin
            rs.rst_meta <= 1'b1;
            rs.rst_sync <= rs.rst_meta;
        end
    end
    assign rst_n = rs.rst_sync;

    flash_divider #(
        .SLOW_HALF (SLOW_HALF),
        .FAST_HALF (FAST_HALF)
    ) u_div (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .slow_phase (slow_phase),
        .fast_phase (fast_phase)
    );

    // Colour gated by pattern phase
    function automatic logic [2:0] show(input colour_t c, input pattern_t p,
                                        input logic sp, input logic fp);
        logic on;
        on = (p == PAT_STEADY) ? 1'b1 : (p == PAT_SLOW) ? sp : fp;
        return on ? c : COL_OFF;
    endfunction

    // Priority chain for the indicator
    always_comb begin
        if (!init_done && init_fault) begin
            next_led = show(COL_RED, PAT_SLOW, slow_phase, fast_phase);
        end else if (!init_done) begin
            next_led = show(COL_RED, PAT_STEADY, slow_phase, fast_phase);
        end else if (over_temp) begin
            next_led = show(COL_RED, PAT_FAST, slow_phase, fast_phase);
        end else if (!link_up) begin
            next_led = show(COL_BLUE, PAT_FAST, slow_phase, fast_phase);
        end else if (!st.valid) begin
            next_led = show(COL_BLUE, PAT_SLOW, slow_phase, fast_phase);
        end else if (acq_free_run) begin
            next_led = show(COL_GREEN, PAT_FAST, slow_phase, fast_phase);
        end else if (acq_triggered) begin
            next_led = show(COL_GREEN, PAT_SLOW, slow_phase, fast_phase);
        end else if (app_connected) begin
            next_led = show(COL_GREEN, PAT_STEADY, slow_phase, fast_phase);
        end else begin
            next_led = show(COL_BLUE, PAT_STEADY, slow_phase, fast_phase);
        end
    end

    // Address sequencer
    always_comb begin
        next_st         = st;
        next_st.led     = next_led;
        next_st.link_d  = link_up;
        next_st.dhcp_go = 1'b0;
        next_st.arp_go  = 1'b0;
        next_st.lfsr    = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
        if (option_wr) begin
            next_st.p_en = persist_en_in;
            next_st.d_en = dhcp_en_in;
        end
        if (st.timer != 32'h0) begin
            next_st.timer = st.timer - 32'h1;
        end
        if (!link_up) begin
            next_st.state = ST_DOWN;
            next_st.valid = 1'b0;
        end else begin
            case (st.state)
                ST_IDLE, ST_DOWN: begin
                    // Power-up and link connection both start here
                    if (st.p_en) begin
                        next_st.state = ST_PERSIST;
                    end else if (st.d_en) begin
                        next_st.state   = ST_DHCP;
                        next_st.dhcp_go = 1'b1;
                        next_st.timer   = STEP_TIMEOUT;
                    end else begin
                        next_st.state = ST_PICK;
                    end
                end
                ST_PERSIST: begin
                    next_st.addr  = persist_addr;
                    next_st.valid = 1'b1;
                    next_st.state = ST_BOUND;
                end
                ST_DHCP: begin
                    if (dhcp_ack) begin
                        next_st.addr  = dhcp_addr;
                        next_st.valid = 1'b1;
                        next_st.state = ST_BOUND;
                    end else if (st.timer == 32'h0) begin
                        next_st.state = ST_PICK;
                    end
                end
                ST_PICK: begin
                    next_st.addr   = {LLA_PREFIX, st.lfsr};
                    next_st.arp_go = 1'b1;
                    next_st.timer  = STEP_TIMEOUT;
                    next_st.state  = ST_PROBE;
                end
                ST_PROBE: begin
                    if (arp_reply) begin
                        next_st.state = ST_PICK;
                    end else if (st.timer == 32'h0) begin
                        next_st.valid = 1'b1;
                        next_st.state = ST_BOUND;
                    end
                end
                default: begin
                    next_st.state = ST_BOUND;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.state <= ST_IDLE;
            st.lfsr  <= LFSR_SEED;
            st.p_en  <= PERSIST_EN_RESET;
            st.d_en  <= DHCP_EN_RESET;
            st.led   <= COL_RED;
        end else begin
            st <= next_st;
        end
    end

    assign dhcp_start      = st.dhcp_go;
    assign arp_probe_start = st.arp_go;
    assign probe_addr      = st.addr;
    assign ip_addr         = st.addr;
    assign addr_valid      = st.valid;
    assign persist_en      = st.p_en;
    assign dhcp_en         = st.d_en;
    assign led_red         = st.led[0];
    assign led_green       = st.led[1];
    assign led_blue        = st.led[2];

    AST_NO_LINK_BLUE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_done && !init_fault && !over_temp && !link_up |=> !led_red && !led_green)
        else $error("no link must show blue only");
    AST_ACQ_OVER_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_done && !over_temp && link_up && st.valid && acq_free_run |=> !led_blue)
        else $error("acquisition must outrank address");
    AST_STEADY_BLUE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_done && !over_temp && link_up && st.valid && !acq_free_run && !acq_triggered
        && !app_connected |=> led_blue)
        else $error("assigned address must show steady blue");
    AST_STEADY_GREEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_done && !over_temp && link_up && st.valid && !acq_free_run && !acq_triggered
        && app_connected |=> led_green && !led_blue)
        else $error("connected app must show steady green");
    AST_UNINIT_RED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !init_done && !init_fault |=> led_red && !led_blue && !led_green)
        else $error("uninitialised must show steady red");
    AST_DHCP_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.state == ST_IDLE && link_up && !st.p_en && st.d_en |=> dhcp_start)
        else $error("dhcp must be tried before link-local");
    AST_LINK_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !link_up ##1 link_up && st.state == ST_DOWN |=> st.state != ST_DOWN)
        else $error("link connection must restart sequence");
    AST_ARP_RETRY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.state == ST_PROBE && link_up && arp_reply |=> !addr_valid ##1 arp_probe_start)
        else $error("answered probe must pick again");
    AST_LLA_SUBNET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(arp_probe_start) |-> probe_addr[31:16] == LLA_PREFIX)
        else $error("probe address must be link-local");
    AST_DEFAULTS: assert property (@(posedge sys_clk) $rose(rst_n) |-> !persist_en && dhcp_en)
        else $error("factory defaults wrong");

    COV_BOUND: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(addr_valid));
    COV_PROBE_RETRY: cover property (@(posedge sys_clk) disable iff (!rst_n)
        st.state == ST_PROBE && arp_reply);
    COV_FREE_RUN: cover property (@(posedge sys_clk) disable iff (!rst_n)
        addr_valid && acq_free_run && led_green);

endmodule

// ===== net_engine_model.sv
module net_engine_model (
    // Clock and link
    input  wire logic        sys_clk,
    input  wire logic        link_up,
    // Requests from the sequencer
    input  wire logic        dhcp_start,
    input  wire logic        arp_probe_start,
    // Scenario settings
    input  wire logic        server_present,
    input  wire logic [31:0] server_addr,
    input  wire logic [1:0]  conflicts,
    // Answers
    output logic             dhcp_ack,
    output logic [31:0]      dhcp_addr,
    output logic             arp_reply
);
    timeunit 1ns;
    timeprecision 1ps;
    int dhcp_wait = 0;
    int arp_wait = 0;
    int replies = 0;
    // Quiet answer lines at start
    initial begin
        dhcp_ack = 1'b0;
        arp_reply = 1'b0;
        dhcp_addr = 32'h0;
    end
    // Answers after a random delay; address lines toggle while not valid
    always @(posedge sys_clk) begin
        dhcp_ack <= 1'b0;
        arp_reply <= 1'b0;
        dhcp_addr <= ~dhcp_addr;
        if (dhcp_start && server_present) dhcp_wait <= 3 + $urandom % 8;
        else if (dhcp_wait > 1) dhcp_wait <= dhcp_wait - 1;
        else if (dhcp_wait == 1) begin
            dhcp_wait <= 0;
            dhcp_ack <= 1'b1;
            dhcp_addr <= server_addr;
        end
        // Only the first conflicts probes since the link came up draw a reply
        if (arp_probe_start && replies < conflicts) begin
            arp_wait <= 2 + $urandom % 6;
            replies <= replies + 1;
        end else if (arp_wait > 1) arp_wait <= arp_wait - 1;
        else if (arp_wait == 1) begin
            arp_wait <= 0;
            arp_reply <= 1'b1;
        end
        if (!link_up) begin
            replies <= 0;
            arp_wait <= 0;
        end
    end
endmodule

// ===== testbench.sv
module testbench import status_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, reset_n = 0, init_done = 0, init_fault = 0, over_temp = 0, link_up = 0;
    logic app_connected = 0, acq_free_run = 0, acq_triggered = 0, option_wr = 0, count_clr = 0;
    logic persist_en_in = 0, dhcp_en_in = 1, server_present = 1;
    logic [31:0] persist_addr = 0, server_addr = 0, probe_addr, dhcp_addr, ip_addr, last_probe;
    logic [1:0] conflicts = 0;
    logic dhcp_start, arp_probe_start, dhcp_ack, arp_reply, addr_valid, persist_en, dhcp_en;
    logic led_red, led_green, led_blue;
    int failures = 0, checks_done = 0, dhcp_starts = 0, probes = 0, mode;
    status_sequencer #(.SLOW_HALF(8), .FAST_HALF(2), .STEP_TIMEOUT(60)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .init_done(init_done), .init_fault(init_fault),
        .over_temp(over_temp), .link_up(link_up), .app_connected(app_connected),
        .acq_free_run(acq_free_run), .acq_triggered(acq_triggered),
        .persist_en_in(persist_en_in), .dhcp_en_in(dhcp_en_in), .option_wr(option_wr),
        .persist_addr(persist_addr), .dhcp_start(dhcp_start),
        .arp_probe_start(arp_probe_start), .probe_addr(probe_addr), .dhcp_ack(dhcp_ack),
        .dhcp_addr(dhcp_addr), .arp_reply(arp_reply), .addr_valid(addr_valid),
        .ip_addr(ip_addr), .persist_en(persist_en), .dhcp_en(dhcp_en),
        .led_red(led_red), .led_green(led_green), .led_blue(led_blue));
    net_engine_model engine (
        .sys_clk(sys_clk), .link_up(link_up), .dhcp_start(dhcp_start),
        .arp_probe_start(arp_probe_start), .server_present(server_present),
        .server_addr(server_addr), .conflicts(conflicts), .dhcp_ack(dhcp_ack),
        .dhcp_addr(dhcp_addr), .arp_reply(arp_reply));
    // Clock
    always #10 sys_clk = ~sys_clk;
    // Request counters, cleared by the bench before each sequence start
    always @(posedge sys_clk) begin
        if (count_clr) begin
            dhcp_starts <= 0;
            probes <= 0;
        end else begin
            if (dhcp_start) dhcp_starts <= dhcp_starts + 1;
            if (arp_probe_start) probes <= probes + 1;
        end
        if (arp_probe_start) last_probe <= probe_addr;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task wait_valid;
        for (int i = 0; i < 600 && addr_valid !== 1'b1; i++) @(negedge sys_clk);
        check("addr_valid wait", 32'(addr_valid), 32'h1);
        if (addr_valid !== 1'b1) end_of_test();
    endtask
    // Watch the indicator and classify its colour and flash rate
    task check_led(input colour_t c, input pattern_t p);
        logic [2:0] col, prev;
        int toggles;
        repeat (3) @(negedge sys_clk);
        prev = {led_blue, led_green, led_red};
        col = prev;
        toggles = 0;
        repeat (40) begin
            @(negedge sys_clk);
            col |= {led_blue, led_green, led_red};
            if ({led_blue, led_green, led_red} !== prev) toggles++;
            prev = {led_blue, led_green, led_red};
        end
        check("led colour", 32'(col), 32'(c));
        check("led pattern", (toggles == 0) ? 0 : (toggles <= 12) ? 1 : 2, 32'(p));
    endtask
    task relink;
        @(posedge sys_clk) link_up <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check("addr_valid drop", 32'(addr_valid), 32'h0);
        @(posedge sys_clk) link_up <= 1'b1;
        count_clr <= 1'b1;
        @(posedge sys_clk) count_clr <= 1'b0;
    endtask
    task options(input logic pe, input logic de);
        @(posedge sys_clk) option_wr <= 1'b1;
        persist_en_in <= pe;
        dhcp_en_in <= de;
        @(posedge sys_clk) option_wr <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("persist_en", 32'(persist_en), 32'(pe));
        check("dhcp_en", 32'(dhcp_en), 32'(de));
    endtask
    function automatic colour_t exp_col(int m, logic app);
        return (m != 0 || app) ? COL_GREEN : COL_BLUE;
    endfunction
    function automatic pattern_t exp_pat(int m);
        return (m == 2) ? PAT_FAST : (m == 1) ? PAT_SLOW : PAT_STEADY;
    endfunction
    initial begin
        void'($urandom(32'hA63E));
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(negedge sys_clk);
        check("persist_en reset", 32'(persist_en), 32'h0);
        check("dhcp_en reset", 32'(dhcp_en), 32'h1);
        check_led(COL_RED, PAT_STEADY);
        @(posedge sys_clk) init_fault <= 1'b1;
        check_led(COL_RED, PAT_SLOW);
        @(posedge sys_clk) init_fault <= 1'b0;
        init_done <= 1'b1;
        check_led(COL_BLUE, PAT_FAST);
        // DHCP server answers
        server_addr <= $urandom;
        relink();
        wait_valid();
        check("dhcp address", ip_addr, server_addr);
        check("probes", 32'(probes), 32'h0);
        check_led(COL_BLUE, PAT_STEADY);
        for (int i = 0; i < 6; i++) begin
            mode = (i < 3) ? i : $urandom % 3;
            @(posedge sys_clk) acq_triggered <= (mode == 1);
            acq_free_run <= (mode == 2);
            app_connected <= 1'($urandom % 2);
            @(posedge sys_clk);
            check_led(exp_col(mode, app_connected), exp_pat(mode));
        end
        @(posedge sys_clk) acq_triggered <= 1'b0;
        acq_free_run <= 1'b0;
        app_connected <= 1'b0;
        over_temp <= 1'b1;
        check_led(COL_RED, PAT_FAST);
        @(posedge sys_clk) over_temp <= 1'b0;
        // No server, one or two probes answered before one stays quiet
        server_present <= 1'b0;
        conflicts <= 2'h1 + 2'($urandom % 2);
        relink();
        check_led(COL_BLUE, PAT_SLOW);
        wait_valid();
        check("lla prefix", 32'(ip_addr[31:16]), 32'(LLA_PREFIX));
        check("lla address", ip_addr, last_probe);
        check("probes", 32'(probes), 32'(conflicts) + 1);
        check("dhcp requests", 32'(dhcp_starts), 32'h1);
        // Persistent address wins, then link-local alone
        persist_addr <= $urandom;
        options(1'b1, 1'b0);
        relink();
        wait_valid();
        check("persistent address", ip_addr, persist_addr);
        check("dhcp requests", 32'(dhcp_starts + probes), 32'h0);
        options(1'b0, 1'b0);
        conflicts <= 2'h0;
        relink();
        wait_valid();
        check("probes only", 32'(probes * 2 + dhcp_starts), 32'h2);
        // Restart at power-up with the link present
        server_present <= 1'b1;
        @(posedge sys_clk) reset_n <= 1'b0;
        count_clr <= 1'b1;
        @(posedge sys_clk) count_clr <= 1'b0;
        @(posedge sys_clk) reset_n <= 1'b1;
        @(negedge sys_clk);
        check("dhcp_en again", 32'(dhcp_en), 32'h1);
        wait_valid();
        check("dhcp restart", 32'(dhcp_starts), 32'h1);
        check("dhcp address", ip_addr, server_addr);
        end_of_test();
    end
endmodule
